// ===== core/lpsm_top.sv
`timescale 1ns/1ps
`default_nettype none
module lpsm_top (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // front side bus pins
  input wire logic STOP_CLOCK_REQUEST_N,
  input wire logic SLEEP_REQUEST_N,
  input wire logic PROC_RESET_N,
  input wire logic SYSTEM_MGMT_INTERRUPT_N,
  input wire logic SOFT_INIT_N,
  input wire logic BUS_INIT_N,
  input wire logic [1:0] LOCAL_INTERRUPT_PINS,
  output logic PENDING_BREAK_EVENT_N,
  // bus unit
  input wire logic FSB_INTERRUPT_MSG,
  input wire logic SNOOP_START,
  input wire logic SNOOP_DONE,
  output logic STOP_GRANT_ACK_REQ,
  input wire logic STOP_GRANT_ACK_RESPONSE,
  // core
  input wire logic [lpsm_pkg::LP_N-1:0] HALT_OR_MONITOR_WAIT,
  input wire logic EHALT_ENABLE,
  input wire logic [lpsm_pkg::EV_N-1:0] EVENT_ACK,
  output logic [lpsm_pkg::EV_N-1:0] SERVICE_EVENTS,
  output logic [lpsm_pkg::LP_N-1:0] LP_HALTED,
  output logic CORE_INIT,
  output logic STOP_GRANT_ACTIVE,
  output logic CLOCKS_STOPPED,
  // operating point
  input wire logic [lpsm_pkg::RATIO_W-1:0] RATIO_FULL,
  input wire logic [lpsm_pkg::RATIO_W-1:0] RATIO_REDUCED,
  input wire logic [lpsm_pkg::VID_W-1:0] VID_FULL,
  input wire logic [lpsm_pkg::VID_W-1:0] VID_REDUCED,
  output logic [lpsm_pkg::RATIO_W-1:0] CORE_RATIO,
  output logic [lpsm_pkg::VID_W-1:0] VOLTAGE_ID_CODE
);

  lpsm_pkg::lpsm_state_type state_reg;
  lpsm_pkg::lpsm_state_type state_next;
  logic [lpsm_pkg::PIN_N-1:0] pin_raw;
  logic [lpsm_pkg::PIN_N-1:0] pin_f;
  logic [lpsm_pkg::PIN_N-1:0] pin_prev_reg;
  logic [lpsm_pkg::EV_N-1:0] ev_edge;
  logic [lpsm_pkg::EV_N-1:0] pend_reg;
  logic [lpsm_pkg::EV_N-1:0] pend_next;
  logic [lpsm_pkg::EV_N-1:0] service_reg;
  logic [lpsm_pkg::LP_N-1:0] halted_reg;
  logic [lpsm_pkg::LP_N-1:0] halted_next;
  logic [lpsm_pkg::CNT_W-1:0] cnt_reg;
  logic [lpsm_pkg::RATIO_W-1:0] ratio_reg;
  logic [lpsm_pkg::VID_W-1:0] vid_reg;
  logic ratio_low_reg;
  logic vid_low_reg;
  logic ret_halt_reg;
  logic pbe_n_reg;
  logic stop_clock_request_n_a;
  logic sleep_a;
  logic reset_a;
  logic cnt_done;
  logic all_halted;
  logic wake;

  function automatic logic in_grant(input lpsm_pkg::lpsm_state_type s);
    return (s == lpsm_pkg::ST_GRANT) || (s == lpsm_pkg::ST_GRANT_SNOOP);
  endfunction

  function automatic logic ratio_low(input lpsm_pkg::lpsm_state_type s);
    return (s == lpsm_pkg::ST_EH_RATIO_DN) || (s == lpsm_pkg::ST_EH_VID_DN) ||
      (s == lpsm_pkg::ST_EHALT) || (s == lpsm_pkg::ST_EHALT_SNOOP) ||
      (s == lpsm_pkg::ST_EH_VID_UP);
  endfunction

  function automatic logic vid_low(input lpsm_pkg::lpsm_state_type s);
    return (s == lpsm_pkg::ST_EH_VID_DN) || (s == lpsm_pkg::ST_EHALT) ||
      (s == lpsm_pkg::ST_EHALT_SNOOP);
  endfunction

  // pin conditioning
  always_comb begin
    pin_raw = lpsm_pkg::PIN_IDLE;
    pin_raw[lpsm_pkg::PIN_STOP_CLOCK_REQUEST_N] = STOP_CLOCK_REQUEST_N;
    pin_raw[lpsm_pkg::PIN_SLP] = SLEEP_REQUEST_N;
    pin_raw[lpsm_pkg::PIN_RESET] = PROC_RESET_N;
    pin_raw[lpsm_pkg::PIN_SMI] = SYSTEM_MGMT_INTERRUPT_N;
    pin_raw[lpsm_pkg::PIN_INIT] = SOFT_INIT_N;
    pin_raw[lpsm_pkg::PIN_BUS_INIT_N] = BUS_INIT_N;
    pin_raw[lpsm_pkg::PIN_LINT0] = LOCAL_INTERRUPT_PINS[0];
    pin_raw[lpsm_pkg::PIN_LINT1] = LOCAL_INTERRUPT_PINS[1];
  end

  lpsm_pin_sync #(
    .WIDTH(lpsm_pkg::PIN_N),
    .IDLE(lpsm_pkg::PIN_IDLE)
  ) u_pin_sync (
    .clk(CLK),
    .nrst(NRST),
    .pin_in(pin_raw),
    .pin_out(pin_f)
  );

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pin_prev_reg <= lpsm_pkg::PIN_IDLE;
    end else begin
      pin_prev_reg <= pin_f;
    end
  end

  assign stop_clock_request_n_a = !pin_f[lpsm_pkg::PIN_STOP_CLOCK_REQUEST_N];
  assign sleep_a = !pin_f[lpsm_pkg::PIN_SLP];
  assign reset_a = !pin_f[lpsm_pkg::PIN_RESET];
  assign cnt_done = (cnt_reg == lpsm_pkg::CNT_ONE);
  assign all_halted = &halted_reg;
  // one wake set for halt and enhanced halt
  assign wake = |pend_reg;

  always_comb begin
    ev_edge = '0;
    ev_edge[lpsm_pkg::EV_SMI] = pin_prev_reg[lpsm_pkg::PIN_SMI] &
      ~pin_f[lpsm_pkg::PIN_SMI];
    ev_edge[lpsm_pkg::EV_INIT] = pin_prev_reg[lpsm_pkg::PIN_INIT] &
      ~pin_f[lpsm_pkg::PIN_INIT];
    ev_edge[lpsm_pkg::EV_BUS_INIT_N] = pin_prev_reg[lpsm_pkg::PIN_BUS_INIT_N] &
      ~pin_f[lpsm_pkg::PIN_BUS_INIT_N];
    ev_edge[lpsm_pkg::EV_LINT0] = ~pin_prev_reg[lpsm_pkg::PIN_LINT0] &
      pin_f[lpsm_pkg::PIN_LINT0];
    ev_edge[lpsm_pkg::EV_LINT1] = ~pin_prev_reg[lpsm_pkg::PIN_LINT1] &
      pin_f[lpsm_pkg::PIN_LINT1];
    ev_edge[lpsm_pkg::EV_FSB] = FSB_INTERRUPT_MSG;
  end

  always_comb begin
    pend_next = (pend_reg & ~(EVENT_ACK &
      {lpsm_pkg::EV_N{state_reg == lpsm_pkg::ST_NORMAL}})) |
      (ev_edge & {lpsm_pkg::EV_N{state_reg != lpsm_pkg::ST_SLEEP}});
    if (reset_a) begin
      pend_next = '0;
    end
  end

  always_comb begin
    halted_next = halted_reg;
    if (wake && ((state_reg == lpsm_pkg::ST_NORMAL) ||
        (state_reg == lpsm_pkg::ST_HALT) ||
        (state_reg == lpsm_pkg::ST_EHALT))) begin
      halted_next = '0;
    end
    if (state_reg == lpsm_pkg::ST_NORMAL) begin
      halted_next = halted_next | HALT_OR_MONITOR_WAIT;
    end
    if (reset_a) begin
      halted_next = '0;
    end
  end

  always_comb begin
    state_next = state_reg;
    if (reset_a) begin
      // reset keeps stop grant, else back to normal
      state_next = in_grant(state_reg) ? lpsm_pkg::ST_GRANT :
        lpsm_pkg::ST_NORMAL;
    end else begin
      case (state_reg)
        lpsm_pkg::ST_NORMAL: begin
          if (stop_clock_request_n_a) begin
            state_next = lpsm_pkg::ST_GRANT_ACK;
          end else if (all_halted && !wake) begin
            state_next = EHALT_ENABLE ? lpsm_pkg::ST_EH_RATIO_DN :
              lpsm_pkg::ST_HALT;
          end
        end
        lpsm_pkg::ST_HALT: begin
          if (wake) begin
            state_next = lpsm_pkg::ST_NORMAL;
          end else if (stop_clock_request_n_a) begin
            state_next = lpsm_pkg::ST_GRANT_ACK;
          end else if (SNOOP_START) begin
            state_next = lpsm_pkg::ST_HALT_SNOOP;
          end
        end
        lpsm_pkg::ST_HALT_SNOOP: begin
          if (SNOOP_DONE) begin
            state_next = lpsm_pkg::ST_HALT;
          end
        end
        lpsm_pkg::ST_EH_RATIO_DN: begin
          if (cnt_done) begin
            state_next = lpsm_pkg::ST_EH_VID_DN;
          end
        end
        lpsm_pkg::ST_EH_VID_DN: begin
          if (cnt_done) begin
            state_next = lpsm_pkg::ST_EHALT;
          end
        end
        lpsm_pkg::ST_EHALT: begin
          if (wake || stop_clock_request_n_a) begin
            state_next = lpsm_pkg::ST_EH_VID_UP;
          end else if (SNOOP_START) begin
            state_next = lpsm_pkg::ST_EHALT_SNOOP;
          end
        end
        lpsm_pkg::ST_EHALT_SNOOP: begin
          if (SNOOP_DONE) begin
            state_next = lpsm_pkg::ST_EHALT;
          end
        end
        lpsm_pkg::ST_EH_VID_UP: begin
          if (cnt_done) begin
            state_next = lpsm_pkg::ST_EH_RATIO_UP;
          end
        end
        lpsm_pkg::ST_EH_RATIO_UP: begin
          if (cnt_done) begin
            state_next = all_halted ? lpsm_pkg::ST_HALT :
              lpsm_pkg::ST_NORMAL;
          end
        end
        lpsm_pkg::ST_GRANT_ACK: begin
          if (STOP_GRANT_ACK_RESPONSE) begin
            state_next = lpsm_pkg::ST_GRANT_DELAY;
          end
        end
        lpsm_pkg::ST_GRANT_DELAY: begin
          if (cnt_done) begin
            state_next = lpsm_pkg::ST_GRANT;
          end
        end
        lpsm_pkg::ST_GRANT: begin
          if (!stop_clock_request_n_a) begin
            state_next = ret_halt_reg ? lpsm_pkg::ST_HALT :
              lpsm_pkg::ST_NORMAL;
          end else if (sleep_a) begin
            state_next = lpsm_pkg::ST_SLEEP;
          end else if (SNOOP_START) begin
            state_next = lpsm_pkg::ST_GRANT_SNOOP;
          end
        end
        lpsm_pkg::ST_GRANT_SNOOP: begin
          if (SNOOP_DONE) begin
            state_next = lpsm_pkg::ST_GRANT;
          end
        end
        lpsm_pkg::ST_SLEEP: begin
          // wake from sleep into stop grant
          if (!sleep_a) begin
            state_next = lpsm_pkg::ST_GRANT;
          end
        end
        default: begin
          state_next = lpsm_pkg::ST_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= lpsm_pkg::ST_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_reg <= lpsm_pkg::CNT_ZERO;
    end else if (state_next != state_reg) begin
      cnt_reg <= (state_next == lpsm_pkg::ST_GRANT_DELAY) ?
        lpsm_pkg::GRANT_DELAY_CNT - lpsm_pkg::CNT_ONE :
        lpsm_pkg::SETTLE_CNT;
    end else if (cnt_reg != lpsm_pkg::CNT_ZERO) begin
      cnt_reg <= cnt_reg - lpsm_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ret_halt_reg <= 1'b0;
    end else if (state_next == lpsm_pkg::ST_GRANT_ACK &&
        state_reg != lpsm_pkg::ST_GRANT_ACK) begin
      ret_halt_reg <= (state_reg == lpsm_pkg::ST_HALT);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ratio_low_reg <= 1'b0;
      vid_low_reg <= 1'b0;
      ratio_reg <= '0;
      vid_reg <= '0;
    end else begin
      ratio_low_reg <= ratio_low(state_next);
      vid_low_reg <= vid_low(state_next);
      ratio_reg <= ratio_low(state_next) ? RATIO_REDUCED : RATIO_FULL;
      vid_reg <= vid_low(state_next) ? VID_REDUCED : VID_FULL;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pend_reg <= '0;
      service_reg <= '0;
      halted_reg <= '0;
      pbe_n_reg <= 1'b1;
    end else begin
      pend_reg <= pend_next;
      service_reg <= (state_next == lpsm_pkg::ST_NORMAL) ? pend_next : '0;
      halted_reg <= halted_next;
      pbe_n_reg <= !(in_grant(state_next) &&
        |(pend_next & lpsm_pkg::INTR_MASK));
    end
  end

  assign PENDING_BREAK_EVENT_N = pbe_n_reg;
  assign STOP_GRANT_ACK_REQ = (state_reg == lpsm_pkg::ST_GRANT_ACK);
  assign SERVICE_EVENTS = service_reg;
  assign LP_HALTED = halted_reg;
  // core initialize while reset pin held
  assign CORE_INIT = reset_a;
  assign STOP_GRANT_ACTIVE = in_grant(state_reg);
  assign CLOCKS_STOPPED = (state_reg == lpsm_pkg::ST_SLEEP);
  assign CORE_RATIO = ratio_reg;
  assign VOLTAGE_ID_CODE = vid_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_plain_halt;
    (state_reg == lpsm_pkg::ST_NORMAL) && all_halted && !EHALT_ENABLE &&
      !wake && !stop_clock_request_n_a && !reset_a |=> state_reg == lpsm_pkg::ST_HALT;
  endproperty
  a_plain_halt: assert property (p_plain_halt)
    else $error("plain halt not entered");

  property p_one_lp;
    (state_reg == lpsm_pkg::ST_NORMAL) && HALT_OR_MONITOR_WAIT == 2'h1 &&
      halted_reg == 2'h0 && !wake && !reset_a |=> LP_HALTED == 2'h1;
  endproperty
  a_one_lp: assert property (p_one_lp)
    else $error("halt spread to other processor");

  property p_wake;
    (state_reg == lpsm_pkg::ST_HALT) && wake && !reset_a |=>
      (state_reg == lpsm_pkg::ST_NORMAL) && LP_HALTED == 2'h0;
  endproperty
  a_wake: assert property (p_wake)
    else $error("halt did not wake");

  property p_reset_grant;
    reset_a && (state_reg == lpsm_pkg::ST_GRANT) |=>
      (state_reg == lpsm_pkg::ST_GRANT) && pend_reg == '0;
  endproperty
  a_reset_grant: assert property (p_reset_grant)
    else $error("reset left stop grant");

  property p_ret_halt;
    (state_reg == lpsm_pkg::ST_GRANT) && !stop_clock_request_n_a && ret_halt_reg &&
      !reset_a |=> state_reg == lpsm_pkg::ST_HALT;
  endproperty
  a_ret_halt: assert property (p_ret_halt)
    else $error("stop clock exit missed halt");

  property p_eh_entry;
    (state_reg == lpsm_pkg::ST_EH_RATIO_DN) &&
      $past(state_reg) == lpsm_pkg::ST_NORMAL |->
      $past(halted_reg) == 2'h3 && $past(EHALT_ENABLE);
  endproperty
  a_eh_entry: assert property (p_eh_entry)
    else $error("enhanced halt entered wrongly");

  // voltage lowered only below reduced ratio
  property p_down_order;
    $rose(vid_low_reg) |-> ratio_low_reg && $past(ratio_low_reg, 2);
  endproperty
  a_down_order: assert property (p_down_order)
    else $error("voltage code lowered before ratio");

  property p_up_order;
    $fell(ratio_low_reg) |-> !vid_low_reg && !$past(vid_low_reg, 2);
  endproperty
  a_up_order: assert property (p_up_order)
    else $error("ratio restored before voltage code");

  property p_grant_delay;
    disable iff (!NRST || reset_a)
    (state_reg == lpsm_pkg::ST_GRANT_ACK) && STOP_GRANT_ACK_RESPONSE |->
      ##19 (state_reg == lpsm_pkg::ST_GRANT_DELAY) ##1
      (state_reg == lpsm_pkg::ST_GRANT);
  endproperty
  a_grant_delay: assert property (p_grant_delay)
    else $error("stop grant entry delay wrong");

  property p_no_service;
    in_grant(state_reg) |-> SERVICE_EVENTS == '0;
  endproperty
  a_no_service: assert property (p_no_service)
    else $error("event serviced in stop grant");

  // bus init latched in stop grant
  property p_bus_init_n_latch;
    (state_reg == lpsm_pkg::ST_GRANT) && ev_edge[lpsm_pkg::EV_BUS_INIT_N] &&
      !reset_a |=> pend_reg[lpsm_pkg::EV_BUS_INIT_N];
  endproperty
  a_bus_init_n_latch: assert property (p_bus_init_n_latch)
    else $error("bus init not latched");

  property p_sleep;
    (state_reg == lpsm_pkg::ST_GRANT) && stop_clock_request_n_a && sleep_a && !reset_a
      |=> state_reg == lpsm_pkg::ST_SLEEP;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep not entered");

  property p_eh_snoop;
    state_reg == lpsm_pkg::ST_EHALT_SNOOP |-> ratio_low_reg && vid_low_reg;
  endproperty
  a_eh_snoop: assert property (p_eh_snoop)
    else $error("enhanced halt snoop lost reduced point");

  property p_pbe;
    in_grant(state_reg) && |(pend_reg & lpsm_pkg::INTR_MASK) |->
      !PENDING_BREAK_EVENT_N;
  endproperty
  a_pbe: assert property (p_pbe)
    else $error("pending break not asserted");

  property p_sleep_reset;
    (state_reg == lpsm_pkg::ST_SLEEP) && reset_a |=>
      state_reg == lpsm_pkg::ST_NORMAL;
  endproperty
  a_sleep_reset: assert property (p_sleep_reset)
    else $error("sleep reset passed stop grant");

endmodule
`default_nettype wire

// ===== core/lpsm_pkg.sv
package lpsm_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int GRANT_DELAY_BCLK = 20;
  localparam int STEP_SETTLE_NS = 100;
  localparam int STEP_SETTLE_CLKS =
    (STEP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] GRANT_DELAY_CNT = CNT_W'(GRANT_DELAY_BCLK);
  localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(STEP_SETTLE_CLKS);

  // widths
  localparam int LP_N = 2;
  localparam int RATIO_W = 6;
  localparam int VID_W = 6;

  // latched event bits
  localparam int EV_N = 6;
  localparam int EV_SMI = 0;
  localparam int EV_INIT = 1;
  localparam int EV_BUS_INIT_N = 2;
  localparam int EV_LINT0 = 3;
  localparam int EV_LINT1 = 4;
  localparam int EV_FSB = 5;
  localparam logic [EV_N-1:0] INTR_MASK = 6'h3B;

  // pin vector layout
  localparam int PIN_N = 8;
  localparam int PIN_STOP_CLOCK_REQUEST_N = 0;
  localparam int PIN_SLP = 1;
  localparam int PIN_RESET = 2;
  localparam int PIN_SMI = 3;
  localparam int PIN_INIT = 4;
  localparam int PIN_BUS_INIT_N = 5;
  localparam int PIN_LINT0 = 6;
  localparam int PIN_LINT1 = 7;
  localparam logic [PIN_N-1:0] PIN_IDLE = 8'h3F;

  typedef enum logic [3:0] {
    ST_NORMAL,
    ST_HALT,
    ST_HALT_SNOOP,
    ST_EH_RATIO_DN,
    ST_EH_VID_DN,
    ST_EHALT,
    ST_EHALT_SNOOP,
    ST_EH_VID_UP,
    ST_EH_RATIO_UP,
    ST_GRANT_ACK,
    ST_GRANT_DELAY,
    ST_GRANT,
    ST_GRANT_SNOOP,
    ST_SLEEP
  } lpsm_state_type;

endpackage

// ===== core/lpsm_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lpsm_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // raw pins and cleaned levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] differ;

  // three stage chain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= IDLE;
      s2_reg <= IDLE;
      s3_reg <= IDLE;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign differ = s2_reg ^ s3_reg;

  // accept a level once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_reg <= IDLE;
    end else begin
      out_reg <= (~differ & s3_reg) | (differ & out_reg);
    end
  end

  assign pin_out = out_reg;

endmodule
`default_nettype wire

// ===== verif/lpsm_chipset.sv
`timescale 1ns/1ps
`default_nettype none
module lpsm_chipset (
  // clock, reset, bench commands
  input wire logic clk,
  input wire logic nrst,
  input wire logic stop_cmd,
  input wire logic sleep_cmd,
  input wire logic rst_cmd,
  input wire logic [3:0] ack_dly,
  // device side
  input wire logic grant,
  input wire logic ack_req,
  output logic stop_n,
  output logic sleep_n,
  output logic rst_n,
  output logic ack_resp
);
  logic slp_hi_reg;
  logic rst_slp_reg;
  logic done_reg;
  logic [3:0] cnt_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stop_n <= 1'b1;
      sleep_n <= 1'b1;
      rst_n <= 1'b1;
      slp_hi_reg <= 1'b1;
      rst_slp_reg <= 1'b0;
    end else begin
      rst_n <= !rst_cmd;
      slp_hi_reg <= sleep_n;
      rst_slp_reg <= !rst_n && (!sleep_n || rst_slp_reg);
      if (stop_cmd && !rst_slp_reg)
        stop_n <= 1'b0;
      else if (rst_slp_reg || (grant && sleep_n && slp_hi_reg))
        stop_n <= 1'b1;
      if (!rst_n || !sleep_cmd)
        sleep_n <= 1'b1;
      else if (grant)
        sleep_n <= 1'b0;
    end
  end
  // ack answer after set delay, once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 4'h0;
      done_reg <= 1'b0;
      ack_resp <= 1'b0;
    end else begin
      ack_resp <= 1'b0;
      if (!ack_req) begin
        cnt_reg <= 4'h0;
        done_reg <= 1'b0;
      end else if (!done_reg && cnt_reg == ack_dly) begin
        ack_resp <= 1'b1;
        done_reg <= 1'b1;
      end else if (!done_reg) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/lpsm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lpsm_top_tb;
  typedef struct packed {
    logic eh;
    logic [2:0] k;
    logic [5:0] ev;
  } lpsm_row_type;
  localparam logic [5:0] rf = 6'h20;
  localparam logic [5:0] rr = 6'h0C;
  localparam logic [5:0] vf = 6'h2A;
  localparam logic [5:0] vr = 6'h15;
  lpsm_row_type rows [12] = '{
    '{1'b0, 3'h0, 6'h01}, '{1'b0, 3'h1, 6'h02}, '{1'b0, 3'h2, 6'h04},
    '{1'b0, 3'h3, 6'h08}, '{1'b0, 3'h4, 6'h10}, '{1'b0, 3'h5, 6'h20},
    '{1'b1, 3'h0, 6'h01}, '{1'b1, 3'h1, 6'h02}, '{1'b1, 3'h2, 6'h04},
    '{1'b1, 3'h3, 6'h08}, '{1'b1, 3'h4, 6'h10}, '{1'b1, 3'h5, 6'h20}};
  int failures = 0;
  int compares = 0;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic stop_cmd = 1'b0;
  logic sleep_cmd = 1'b0;
  logic rst_cmd = 1'b0;
  logic [3:0] dly = 4'h0;
  logic smi_n = 1'b1;
  logic init_n = 1'b1;
  logic bus_init_n_n = 1'b1;
  logic [1:0] lint = 2'h0;
  logic fsb = 1'b0;
  logic snp_s = 1'b0;
  logic snp_d = 1'b0;
  logic [1:0] halt = 2'h0;
  logic eh_en = 1'b0;
  logic [5:0] ev_ack = 6'h00;
  logic in_rst = 1'b0;
  logic bad_ord = 1'b0;
  logic mid = 1'b0;
  logic bad_rst = 1'b0;
  logic stop_n, sleep_n, rst_n, ack_resp, ack_req, pbe_n;
  logic core_init, grant, clk_off;
  logic [1:0] lp;
  logic [5:0] svc, ratio, voltage_id_code;
  always #10 clk = ~clk;
  lpsm_top i_dut (
    .CLK(clk), .NRST(nrst), .STOP_CLOCK_REQUEST_N(stop_n),
    .SLEEP_REQUEST_N(sleep_n), .PROC_RESET_N(rst_n),
    .SYSTEM_MGMT_INTERRUPT_N(smi_n), .SOFT_INIT_N(init_n),
    .BUS_INIT_N(bus_init_n_n), .LOCAL_INTERRUPT_PINS(lint),
    .PENDING_BREAK_EVENT_N(pbe_n), .FSB_INTERRUPT_MSG(fsb),
    .SNOOP_START(snp_s), .SNOOP_DONE(snp_d),
    .STOP_GRANT_ACK_REQ(ack_req), .STOP_GRANT_ACK_RESPONSE(ack_resp),
    .HALT_OR_MONITOR_WAIT(halt), .EHALT_ENABLE(eh_en),
    .EVENT_ACK(ev_ack), .SERVICE_EVENTS(svc), .LP_HALTED(lp),
    .CORE_INIT(core_init), .STOP_GRANT_ACTIVE(grant),
    .CLOCKS_STOPPED(clk_off), .RATIO_FULL(rf), .RATIO_REDUCED(rr),
    .VID_FULL(vf), .VID_REDUCED(vr), .CORE_RATIO(ratio),
    .VOLTAGE_ID_CODE(voltage_id_code));
  lpsm_chipset i_chip (
    .clk(clk), .nrst(nrst), .stop_cmd(stop_cmd), .sleep_cmd(sleep_cmd),
    .rst_cmd(rst_cmd), .ack_dly(dly), .grant(grant), .ack_req(ack_req),
    .stop_n(stop_n), .sleep_n(sleep_n), .rst_n(rst_n),
    .ack_resp(ack_resp));
  always @(posedge clk) begin
    if (nrst && voltage_id_code === vr && ratio === rf)
      bad_ord <= 1'b1;
    if (nrst && voltage_id_code === vf && ratio === rr)
      mid <= 1'b1;
    if (in_rst && grant === 1'b1)
      bad_rst <= 1'b1;
  end
  task automatic chk_vec(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic cond(input int w);
    case (w)
      0: return lp === 2'h0;
      1: return voltage_id_code === vr;
      2: return grant === 1'b1;
      3: return clk_off === 1'b1;
      4: return grant === 1'b0;
      5: return ack_resp === 1'b1;
      6: return core_init === 1'b1;
      7: return core_init === 1'b0;
      default: return lp === 2'h3;
    endcase
  endfunction
  task automatic await(input int w);
    int n;
    #1;
    n = 0;
    while (!cond(w) && n < 200) begin
      @(posedge clk) #1;
      n++;
    end
    if (n == 200)
      chk_vec(6'(w), 6'h3F);
  endtask
  task automatic fire(input logic [2:0] k);
    @(posedge clk);
    case (k)
      3'h0: smi_n <= 1'b0;
      3'h1: init_n <= 1'b0;
      3'h2: bus_init_n_n <= 1'b0;
      3'h3: lint[0] <= 1'b1;
      3'h4: lint[1] <= 1'b1;
      default: fsb <= 1'b1;
    endcase
    @(posedge clk) fsb <= 1'b0;
    repeat (6) @(posedge clk);
    smi_n <= 1'b1;
    init_n <= 1'b1;
    bus_init_n_n <= 1'b1;
    lint <= 2'h0;
    repeat (6) @(posedge clk) #1;
  endtask
  task automatic snoop();
    @(posedge clk) snp_s <= 1'b1;
    @(posedge clk) snp_s <= 1'b0;
    repeat (3) @(posedge clk);
    snp_d <= 1'b1;
    @(posedge clk) snp_d <= 1'b0;
    repeat (3) @(posedge clk) #1;
  endtask
  task automatic ack(input logic [5:0] m);
    // enhanced halt exit needs two settle steps before normal
    repeat (4) @(posedge clk) #1;
    chk_vec(svc, m);
    @(posedge clk) ev_ack <= m;
    @(posedge clk) ev_ack <= 6'h00;
    repeat (2) @(posedge clk) #1;
    chk_vec(svc, 6'h00);
  endtask
  task automatic halt_both();
    @(posedge clk) halt <= 2'h1;
    @(posedge clk) halt <= 2'h0;
    repeat (3) @(posedge clk) #1;
    chk_vec({4'h0, lp}, 6'h01);
    chk_vec(ratio, rf);
    @(posedge clk) halt <= 2'h2;
    @(posedge clk) halt <= 2'h0;
    await(8);
  endtask
  task automatic enter_grant(input logic [3:0] d);
    int n;
    @(posedge clk) dly <= d;
    @(posedge clk) stop_cmd <= 1'b1;
    await(5);
    n = 0;
    while (grant !== 1'b1 && n < 40) begin
      @(posedge clk) #1;
      n++;
      if (n == 1)
        chk_vec({5'h00, ack_req}, 6'h00);
    end
    chk_vec(6'(n), 6'h14);
  endtask
  task automatic leave_grant();
    @(posedge clk) stop_cmd <= 1'b0;
    await(4);
  endtask
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      @(posedge clk) eh_en <= rows[i].eh;
      halt_both();
      if (rows[i].eh)
        await(1);
      repeat (6) @(posedge clk);
      snoop();
      chk_vec(ratio, rows[i].eh ? rr : rf);
      chk_vec(voltage_id_code, rows[i].eh ? vr : vf);
      chk_vec({4'h0, lp}, 6'h03);
      fire(rows[i].k);
      await(0);
      chk_vec(voltage_id_code, vf);
      chk_vec(ratio, rf);
      ack(rows[i].ev);
    end
    @(posedge clk) eh_en <= 1'b0;
    enter_grant(4'h0);
    fire(3'h2);
    chk_vec({5'h00, pbe_n}, 6'h01);
    fire(3'h0);
    fire(3'h0);
    chk_vec(svc, 6'h00);
    chk_vec({5'h00, pbe_n}, 6'h00);
    snoop();
    chk_vec({5'h00, grant}, 6'h01);
    @(posedge clk) sleep_cmd <= 1'b1;
    await(3);
    chk_vec({5'h00, grant}, 6'h00);
    @(posedge clk) sleep_cmd <= 1'b0;
    await(2);
    leave_grant();
    ack(6'h05);
    halt_both();
    enter_grant(4'h7);
    // a detour through normal would now start enhanced halt entry
    @(posedge clk) eh_en <= 1'b1;
    leave_grant();
    repeat (3) @(posedge clk) #1;
    chk_vec({4'h0, lp}, 6'h03);
    chk_vec(ratio, rf);
    fire(3'h5);
    await(0);
    ack(6'h20);
    enter_grant(4'h2);
    @(posedge clk) rst_cmd <= 1'b1;
    await(6);
    chk_vec({5'h00, grant}, 6'h01);
    @(posedge clk) rst_cmd <= 1'b0;
    await(7);
    chk_vec({5'h00, grant}, 6'h01);
    leave_grant();
    enter_grant(4'h1);
    @(posedge clk) sleep_cmd <= 1'b1;
    await(3);
    @(posedge clk) rst_cmd <= 1'b1;
    in_rst <= 1'b1;
    await(6);
    @(posedge clk) sleep_cmd <= 1'b0;
    stop_cmd <= 1'b0;
    repeat (8) @(posedge clk);
    rst_cmd <= 1'b0;
    await(7);
    repeat (6) @(posedge clk) #1;
    chk_vec({4'h0, bad_rst, clk_off}, 6'h00);
    chk_vec({4'h0, bad_ord, mid}, 6'h01);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
